// [rtl/dc_flags.v]
// Data-control status flags of the processor, steered by clock steps, with an APB slave
//
// Local design decisions: register access over APB and the register addresses.
`include "dc_flags_map.vh"

// How it works
// - Arith control set T3 address, any step store-index/E1
// - Arith control set on tagged I2/modify cycles
// - Arith control cleared T0 on op reset
// - Divide clears arith control on end conditions
// - Shift control set T3 shift/multiply
// - Shift control cleared on zero count/reset
// - Add flag set T3 when D added
// - Divide E1 clears add with sign
// - Arith sign set on divide/add/multiply conditions
// - Arith sign reset T3/T1 divide/reset
// - Zero remainder set at count one
// - Zero remainder cleared like signs, B0 set
// - Branch one set T6, lasts one cycle
// - Branch two set T7, cleared with one
// - Protect bit set on core read with protect sense
// - Protect bit set by store status write
// - Protect bit cleared by store/clear-storage
// - Parity loaded on read, drives inhibit
// - Parity from bus generators, B reset
// - Interrupt service; master request cleared T7
// - Cycle steal latch for levels or timer
// - Auxiliary select by switch or CE interrupt
module dc_flags #(
  parameter CS_LEVELS = `CS_LEVELS
) (
  // APB slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Processor timing
  input  wire [2:0]  t_step,
  input  wire        b_phase,
  // Core storage
  input  wire        core_read,
  input  wire        core_write,
  input  wire        prot_sense,
  input  wire        parity_sense,
  // Bus parity generators
  input  wire        in_bus_par_valid,
  input  wire        in_bus_par,
  input  wire        out_bus_par_valid,
  input  wire        out_bus_par,
  // Interrupt and cycle steal
  input  wire        irq_request,
  input  wire        irq_enable,
  input  wire [CS_LEVELS-1:0] cs_level_req,
  input  wire        timer_cs_req,
  input  wire        cs_cycle_end,
  // Flag outputs
  output reg         inhibit_one_ff,
  output reg         int_service_ff,
  output reg         aux_select_ff,
  output reg         branch2_out_ff
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  reg [31:0] cond_ff;
  reg [5:0]  shift_cnt_ff;
  reg [6:0]  ctrl_ff;
  reg        rst_op_ff;
  reg        rst_b_ff;
  reg        arith_ctl_ff, shift_ctl_ff, add_ff, arith_sign_ff, zero_rem_ff;
  reg        branch1_ff, branch2_ff, prot_bit_ff, parity_ff, master_irq_ff;
  reg        cs_active_ff;
  reg        dp_carry_d_ff;
  // Pin inputs synchronised in two stages, except t_step and the bus parity lines
  reg [8:0]  sync1_ff;
  reg [8:0]  sync2_ff;

  wire wr = psel & penable & pwrite;
  wire t0 = (t_step == `STEP_T0);
  wire t1 = (t_step == `STEP_T1);
  wire t2 = (t_step == `STEP_T2);
  wire t3 = (t_step == `STEP_T3);
  wire t6 = (t_step == `STEP_T6);
  wire t7 = (t_step == `STEP_T7);
  wire [31:0] c = cond_ff;
  wire sc_zero = (shift_cnt_ff == `SC_ZERO);
  wire sc_one  = (shift_cnt_ff == `SC_ONE);
  wire div_e   = c[`C_OP_DIV] & c[`C_CYC_E];

  wire s_core_read  = sync2_ff[0];
  wire s_core_write = sync2_ff[1];
  wire s_prot_sense = sync2_ff[2];
  wire s_par_sense  = sync2_ff[3];
  wire s_irq        = sync2_ff[4];
  wire s_irq_en     = sync2_ff[5];
  wire s_cs_end     = sync2_ff[6];
  wire s_bphase     = sync2_ff[7];
  wire s_timer_cs   = sync2_ff[8];

  // ----------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------
  reg [CS_LEVELS-1:0] cs_s1_ff, cs_s2_ff;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_ff <= 9'h000;
      sync2_ff <= 9'h000;
      cs_s1_ff <= {CS_LEVELS{1'b0}};
      cs_s2_ff <= {CS_LEVELS{1'b0}};
    end else begin
      sync1_ff <= {timer_cs_req, b_phase, cs_cycle_end, irq_enable, irq_request,
                   parity_sense, prot_sense, core_write, core_read};
      sync2_ff <= sync1_ff;
      cs_s1_ff <= cs_level_req;
      cs_s2_ff <= cs_s1_ff;
    end
  end

  // ----------------------------------------------------------------
  // APB slave: zero wait states, unmapped offsets flag an error
  // ----------------------------------------------------------------
  wire mapped = (paddr == `OFS_CTRL) | (paddr == `OFS_STATUS) | (paddr == `OFS_COND) |
                (paddr == `OFS_SHIFTCNT) | (paddr == `OFS_FLAGS);
  wire [31:0] status = {19'h00000, master_irq_ff, aux_select_ff, cs_active_ff,
                        int_service_ff, parity_ff, prot_bit_ff, branch2_ff, branch1_ff,
                        zero_rem_ff, arith_sign_ff, add_ff, shift_ctl_ff, arith_ctl_ff};
  reg [31:0] nxt_prdata;
  always @* begin
    case (paddr)
      `OFS_CTRL:     nxt_prdata = {25'h0000000, ctrl_ff};
      `OFS_STATUS:   nxt_prdata = status;
      `OFS_COND:     nxt_prdata = cond_ff;
      `OFS_SHIFTCNT: nxt_prdata = {26'h0000000, shift_cnt_ff};
      `OFS_FLAGS:    nxt_prdata = status;
      default:       nxt_prdata = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata  <= (psel & ~penable & ~pwrite) ? nxt_prdata : prdata;
    end
  end

  // Register writes: reset lines are one-cycle pulses, switches are levels
  wire acc = psel & penable & pready;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff      <= 7'h00;
      cond_ff      <= 32'h00000000;
      shift_cnt_ff <= 6'h00;
      rst_op_ff    <= 1'b0;
      rst_b_ff     <= 1'b0;
    end else begin
      rst_op_ff <= acc & wr & (paddr == `OFS_CTRL) & pwdata[`CTRL_RST_OP];
      rst_b_ff  <= acc & wr & (paddr == `OFS_CTRL) & pwdata[`CTRL_RST_B];
      if (acc & wr & (paddr == `OFS_CTRL)) begin
        ctrl_ff <= pwdata[6:0] & 7'h7C;
      end
      if (acc & wr & (paddr == `OFS_COND)) begin
        cond_ff <= pwdata;
      end
      if (acc & wr & (paddr == `OFS_SHIFTCNT)) begin
        shift_cnt_ff <= pwdata[5:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Flag logic
  // ----------------------------------------------------------------
  wire arith_set = (t3 & c[`C_CYC_I1] & c[`C_NEED_EA])
                 | (c[`C_CYC_I1] & c[`C_OP_STX])
                 | (c[`C_CYC_E1] & c[`C_OP_ARITH] & ~c[`C_OP_MUL])
                 | (c[`C_CYC_E1] & c[`C_OP_MDX])
                 | (c[`C_CYC_I2] & c[`C_TAG_NZ] & ~c[`C_IDX_OP])
                 | (c[`C_OP_MDX] & (c[`C_CYC_I2] | c[`C_CYC_IA])
                    & c[`C_FORMAT] & c[`C_TAG_NZ]);
  wire arith_clr = (t0 & rst_op_ff)
                 | (c[`C_OP_DIV] & (c[`C_DIV_RST_A] | sc_zero | sc_one))
                 | (c[`C_OP_DIV] & c[`C_D_ZERO] & dp_carry_d_ff & ~c[`C_DP_CARRY]);

  wire shift_set = t3 & (c[`C_OP_SHIFT] | (c[`C_OP_MUL] & c[`C_CYC_E]));
  wire shift_clr = rst_op_ff
                 | ((c[`C_CYC_I1] | c[`C_CYC_I2] | c[`C_CYC_IA]) & sc_zero)
                 | (s_bphase & c[`C_OP_SHIFT] & (sc_zero | c[`C_SLC_BIT]));

  wire sign_set = (t2 & div_e & c[`C_ACC_B0])
                | (t3 & c[`C_CYC_E] & (c[`C_OP_ADD] | c[`C_OP_SUB]) & c[`C_SIGN_DIFF])
                | (t3 & c[`C_CYC_E] & (c[`C_OP_DIV] | c[`C_OP_MUL]) & c[`C_BLATCH_B0]);
  // Held-over set at T3 resets the sign before the new decision
  wire sign_clr = (t3 & arith_sign_ff & sign_set)
                | (t1 & div_e) | rst_op_ff;

  wire add_set = t3 & c[`C_ADD_D2A] & ~c[`C_OP_SUB];
  wire add_clr = rst_op_ff | (c[`C_CYC_E1] & c[`C_OP_DIV] & sign_clr);

  wire zr_set = t3 & div_e & sc_one;
  wire zr_clr = (t3 & div_e & sc_one & ~arith_sign_ff & c[`C_BLATCH_B0])
              | rst_op_ff;

  wire br1_set = t6 & (c[`C_OP_SLC] | c[`C_OP_LDX] | c[`C_OP_MDX]
                 | (c[`C_OP_BSC] & c[`C_FORMAT]));

  wire sts_form = c[`C_OP_STS] & c[`C_FORMAT] & c[`C_MOD9];
  wire prot_set = t3 & c[`C_MOD15] & ctrl_ff[`CTRL_PROT_WR_SW] & sts_form;
  wire prot_clr = t3 & ~c[`C_MOD15] & ctrl_ff[`CTRL_PROT_WR_SW]
                  & (sts_form | ctrl_ff[`CTRL_CLR_STOR]);

  // ----------------------------------------------------------------
  // Arithmetic and shift flags
  // ----------------------------------------------------------------
  // Delayed copy of the carry line, so its fall is seen as an edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dp_carry_d_ff <= 1'b0;
    end else begin
      dp_carry_d_ff <= c[`C_DP_CARRY];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arith_ctl_ff <= 1'b0;
    end else if (arith_clr) begin
      arith_ctl_ff <= 1'b0;
    end else if (arith_set) begin
      arith_ctl_ff <= 1'b1;
    end
  end

  // Set wins: a new shift at T3 must not be lost to a stale zero count
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_ctl_ff <= 1'b0;
    end else if (shift_set) begin
      shift_ctl_ff <= 1'b1;
    end else if (shift_clr) begin
      shift_ctl_ff <= 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      add_ff <= 1'b0;
    end else if (add_clr) begin
      add_ff <= 1'b0;
    end else if (add_set) begin
      add_ff <= 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arith_sign_ff <= 1'b0;
    end else if (sign_clr) begin
      arith_sign_ff <= 1'b0;
    end else if (sign_set) begin
      arith_sign_ff <= 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zero_rem_ff <= 1'b0;
    end else if (zr_clr) begin
      zero_rem_ff <= 1'b0;
    end else if (zr_set) begin
      zero_rem_ff <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Branch flags
  // ----------------------------------------------------------------
  // Branch one lives one cycle; branch two follows at T7 of that cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      branch1_ff <= 1'b0;
    end else begin
      branch1_ff <= br1_set & ~rst_op_ff;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      branch2_ff <= 1'b0;
    end else if (~branch1_ff & ~br1_set | rst_op_ff) begin
      branch2_ff <= 1'b0;
    end else if (t7 & branch1_ff & c[`C_NONARITH]) begin
      branch2_ff <= 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      branch2_out_ff <= 1'b0;
    end else begin
      branch2_out_ff <= branch2_ff;
    end
  end

  // ----------------------------------------------------------------
  // Storage flags
  // ----------------------------------------------------------------
  // Read sense wins over B reset so a protect bit is never lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_bit_ff <= 1'b0;
    end else if ((s_core_read & s_prot_sense) | prot_set) begin
      prot_bit_ff <= 1'b1;
    end else if (rst_b_ff | prot_clr) begin
      prot_bit_ff <= 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parity_ff <= 1'b0;
    end else if (s_core_read) begin
      parity_ff <= s_par_sense;
    end else if (in_bus_par_valid) begin
      parity_ff <= in_bus_par;
    end else if (out_bus_par_valid) begin
      parity_ff <= out_bus_par;
    end else if (rst_b_ff) begin
      parity_ff <= 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inhibit_one_ff <= 1'b0;
    end else begin
      inhibit_one_ff <= s_core_write & parity_ff;
    end
  end

  // ----------------------------------------------------------------
  // Service, steal and auxiliary flags
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_irq_ff <= 1'b0;
    end else if (s_irq) begin
      master_irq_ff <= 1'b1;
    end else if (t7 & c[`C_CYC_I2] & sc_zero) begin
      master_irq_ff <= 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_service_ff <= 1'b0;
    end else begin
      int_service_ff <= master_irq_ff & s_irq_en;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_active_ff <= 1'b0;
    end else if ((|cs_s2_ff) | s_timer_cs) begin
      cs_active_ff <= 1'b1;
    end else if (s_cs_end) begin
      cs_active_ff <= 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      aux_select_ff <= 1'b0;
    end else begin
      aux_select_ff <= ctrl_ff[`CTRL_FORCE_AUX]
                     | (ctrl_ff[`CTRL_CE_INT] & ctrl_ff[`CTRL_INT_TO_AUX]);
    end
  end

endmodule

// [rtl/dc_flags_map.vh]
// Register offsets, field positions and timing constants for the data-control flags
`ifndef DC_FLAGS_MAP_VH
`define DC_FLAGS_MAP_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OFS_CTRL      12'h000
`define OFS_STATUS    12'h004
`define OFS_COND      12'h008
`define OFS_SHIFTCNT  12'h00C
`define OFS_FLAGS     12'h010

// ----------------------------------------------------------------
// Control register fields (write 1 pulses, levels for switches)
// ----------------------------------------------------------------
`define CTRL_RST_OP       0
`define CTRL_RST_B        1
`define CTRL_FORCE_AUX    2
`define CTRL_CE_INT       3
`define CTRL_INT_TO_AUX   4
`define CTRL_PROT_WR_SW   5
`define CTRL_CLR_STOR     6
`define CTRL_LEVEL_MASK   32'h0000007C

// ----------------------------------------------------------------
// Condition register fields (decoded instruction state, levels)
// ----------------------------------------------------------------
`define C_CYC_I1     0
`define C_CYC_I2     1
`define C_CYC_IA     2
`define C_CYC_E1     3
`define C_CYC_E      4
`define C_NEED_EA    5
`define C_OP_STX     6
`define C_OP_ARITH   7
`define C_OP_MUL     8
`define C_OP_DIV     9
`define C_OP_ADD     10
`define C_OP_SUB     11
`define C_OP_MDX     12
`define C_OP_LDX     13
`define C_OP_BSC     14
`define C_OP_SHIFT   15
`define C_OP_SLC     16
`define C_OP_STS     17
`define C_FORMAT     18
`define C_TAG_NZ     19
`define C_MOD9       20
`define C_MOD15      21
`define C_IDX_OP     22
`define C_SIGN_DIFF  23
`define C_ACC_B0     24
`define C_BLATCH_B0  25
`define C_D_ZERO     26
`define C_DP_CARRY   27
`define C_DIV_RST_A  28
`define C_SLC_BIT    29
`define C_ADD_D2A    30
`define C_NONARITH   31

// ----------------------------------------------------------------
// Status register bit positions
// ----------------------------------------------------------------
`define S_ARITH_CTL  0
`define S_SHIFT_CTL  1
`define S_ADD        2
`define S_ARITH_SIGN 3
`define S_ZERO_REM   4
`define S_BRANCH1    5
`define S_BRANCH2    6
`define S_PROT_BIT   7
`define S_PARITY     8
`define S_INT_SVC    9
`define S_CS_ACTIVE  10
`define S_AUX_SEL    11
`define S_MASTER_IRQ 12

// ----------------------------------------------------------------
// Clock steps and counts
// ----------------------------------------------------------------
`define STEP_T0  3'h0
`define STEP_T1  3'h1
`define STEP_T2  3'h2
`define STEP_T3  3'h3
`define STEP_T6  3'h6
`define STEP_T7  3'h7
`define SC_ZERO  6'h00
`define SC_ONE   6'h01
`define CS_LEVELS 9

`endif

// [bench/dc_flags_assertions.sv]
// Port-level assertions for the data-control flags block
module dc_flags_assertions (
  // APB
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire        pready,
  input wire        pslverr,
  // Pins and flags
  input wire        core_write,
  input wire        irq_enable,
  input wire        inhibit_one_ff,
  input wire        int_service_ff,
  input wire        aux_select_ff
);
  logic aux_exp_ff;
  wire  setup = psel && !penable;
  wire  xfer  = psel && penable && pready;
  wire  unmap = paddr[1:0] == 2'h0 && paddr > 12'h010;

  // Track the panel levels last written so the select output can be judged
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      aux_exp_ff <= 1'b0;
    else if (xfer && pwrite && paddr == 12'h000)
      aux_exp_ff <= pwdata[2] | (pwdata[3] & pwdata[4]);
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ready_after_setup: assert property (setup |=> pready)
    else $error("no ready after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_on_unmapped: assert property (setup && unmap |=> pslverr)
    else $error("unmapped not refused");
  a_no_err_mapped: assert property (setup && paddr[1:0] == 2'h0 && !unmap |=> !pslverr)
    else $error("mapped access refused");
  a_unmapped_read_zero: assert property (setup && unmap && !pwrite |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_quiet_after_reset: assert property
    ($rose(presetn) |-> !(inhibit_one_ff || int_service_ff || aux_select_ff))
    else $error("output set after reset");
  a_inhibit_cause: assert property ($rose(inhibit_one_ff) |->
    $past(core_write, 2) || $past(core_write, 3) || $past(core_write, 4))
    else $error("inhibit without write");
  a_service_enable: assert property (int_service_ff |->
    $past(irq_enable, 2) || $past(irq_enable, 3) || $past(irq_enable, 4))
    else $error("service without enable");
  a_aux_follows: assert property (xfer && pwrite && paddr == 12'h000 |=>
    ##[1:3] aux_select_ff == aux_exp_ff)
    else $error("aux select wrong");
endmodule

bind dc_flags dc_flags_assertions u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .core_write(core_write), .irq_enable(irq_enable), .inhibit_one_ff(inhibit_one_ff),
  .int_service_ff(int_service_ff), .aux_select_ff(aux_select_ff));

// [bench/testbench.sv]
// Self-checking bench for the data-control flags block
`include "dc_flags_map.vh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, b_phase, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q, d;
  logic        pready, pslverr, core_read, core_write, prot_sense, parity_sense;
  logic        in_v, in_p, out_v, out_p, irq_request, irq_enable, timer_cs_req, cs_cycle_end;
  logic [8:0]  cs_level_req;
  logic [2:0]  t_step;
  logic        inhibit_one_ff, int_service_ff, aux_select_ff, branch2_out_ff;
  int          fails, compares, seed, n;
  int          ops [4] = '{`C_OP_SLC, `C_OP_LDX, `C_OP_MDX, `C_OP_BSC};

  dc_flags i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .t_step(t_step), .b_phase(b_phase), .core_read(core_read), .core_write(core_write),
    .prot_sense(prot_sense), .parity_sense(parity_sense), .in_bus_par_valid(in_v),
    .in_bus_par(in_p), .out_bus_par_valid(out_v), .out_bus_par(out_p),
    .irq_request(irq_request), .irq_enable(irq_enable), .cs_level_req(cs_level_req),
    .timer_cs_req(timer_cs_req), .cs_cycle_end(cs_cycle_end),
    .inhibit_one_ff(inhibit_one_ff), .int_service_ff(int_service_ff),
    .aux_select_ff(aux_select_ff), .branch2_out_ff(branch2_out_ff));

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] bit_of(input int i);
    return 32'h1 << i;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer, then an idle edge so back-to-back calls never collide
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    q = prdata;
    err = pslverr;
    if (k >= 20) fails++;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask

  task automatic stat(input logic [31:0] mask, input logic [31:0] exp);
    apb(1'b0, `OFS_STATUS, 32'h0);
    chk(q & mask, exp);
  endtask

  task automatic setc(input logic [31:0] c, input logic [2:0] s);
    apb(1'b1, `OFS_COND, c);
    t_step <= s;
    repeat (4) @(posedge pclk);
  endtask

  task automatic summarize;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    seed = 32'h2C7F;
    {psel, penable, pwrite, paddr, pwdata, t_step, b_phase} = '0;
    {core_read, core_write, prot_sense, parity_sense, in_v, in_p, out_v, out_p} = '0;
    {irq_request, irq_enable, cs_level_req, timer_cs_req, cs_cycle_end} = '0;
    presetn = 1'b0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    stat(32'hFFFFFFFF, 32'h0);
    apb(1'b0, `OFS_FLAGS, 32'h0);
    chk(q, 32'h0);
    d = $random(seed);
    apb(1'b1, `OFS_SHIFTCNT, {26'h0, d[5:0]});
    apb(1'b0, `OFS_SHIFTCNT, 32'h0);
    chk(q, {26'h0, d[5:0]});
    apb(1'b0, 12'hFFC, 32'h0);
    chk({err, q[30:0]}, 32'h80000000);
    $display("test registers done");
    for (int i = 0; i < 2; i++) begin
      d = i ? bit_of(`C_CYC_I2) | bit_of(`C_TAG_NZ) : bit_of(`C_CYC_I1) | bit_of(`C_NEED_EA)
          | bit_of(`C_OP_SHIFT) | bit_of(`C_ADD_D2A);
      setc(d, `STEP_T3);
      stat(32'h7, i ? 32'h1 : 32'h7);
      setc(32'h0, `STEP_T0);
      apb(1'b1, `OFS_CTRL, 32'h1);
      stat(32'h7, 32'h0);
    end
    apb(1'b1, `OFS_SHIFTCNT, 32'h1);
    setc(bit_of(`C_CYC_E) | bit_of(`C_OP_DIV), `STEP_T3);
    stat(32'h10, 32'h10);
    setc(32'h0, `STEP_T0);
    apb(1'b1, `OFS_CTRL, 32'h1);
    stat(32'h10, 32'h0);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `OFS_COND, bit_of(`C_NONARITH) | bit_of(`C_FORMAT) | bit_of(ops[i]));
      n = 0;
      for (int s = 6; s < 13; s++) begin
        t_step <= s[2:0];
        @(posedge pclk);
        n += (branch2_out_ff === 1'b1);
      end
      chk(n != 0, 1'b1);
    end
    setc(32'h0, `STEP_T0);
    apb(1'b1, `OFS_SHIFTCNT, 32'h5);
    d = bit_of(`C_CYC_E) | bit_of(`C_CYC_E1) | bit_of(`C_OP_DIV) | bit_of(`C_ACC_B0)
        | bit_of(`C_ADD_D2A);
    setc(d, `STEP_T3);
    setc(d, `STEP_T2);
    stat(32'hC, 32'hC);
    setc(d, `STEP_T1);
    stat(32'hC, 32'h0);
    setc(bit_of(`C_CYC_E1) | bit_of(`C_OP_ARITH), `STEP_T0);
    stat(32'h1, 32'h1);
    setc(bit_of(`C_OP_DIV) | bit_of(`C_DIV_RST_A), `STEP_T0);
    stat(32'h1, 32'h0);
    setc(32'h0, `STEP_T0);
    $display("test sequencing flags done");
    repeat (12) begin
      d = $random(seed) & `CTRL_LEVEL_MASK;
      apb(1'b1, `OFS_CTRL, d);
      repeat (2) @(posedge pclk);
      chk(aux_select_ff, d[2] | (d[3] & d[4]));
    end
    $display("test aux select done");
    {core_read, prot_sense, parity_sense} <= 3'b111;
    repeat (4) @(posedge pclk);
    {core_read, prot_sense, parity_sense} <= 3'b000;
    stat(32'h180, 32'h180);
    core_write <= 1'b1;
    repeat (5) @(posedge pclk);
    chk(inhibit_one_ff, 1'b1);
    core_write <= 1'b0;
    apb(1'b1, `OFS_CTRL, 32'h2);
    stat(32'h180, 32'h0);
    for (int i = 0; i < 4; i++) begin
      {in_v, in_p, out_v, out_p} <= {~i[1], ~i[0], i[1], ~i[0]};
      repeat (2) @(posedge pclk);
      stat(32'h100, {23'h0, ~i[0], 8'h0});
    end
    {in_v, out_v} <= 2'b00;
    apb(1'b1, `OFS_CTRL, 32'h20);
    d = bit_of(`C_OP_STS) | bit_of(`C_FORMAT) | bit_of(`C_MOD9);
    setc(d | bit_of(`C_MOD15), `STEP_T3);
    stat(32'h80, 32'h80);
    setc(d, `STEP_T3);
    stat(32'h80, 32'h0);
    setc(32'h0, `STEP_T0);
    $display("test storage flags done");
    for (int i = 0; i < 10; i++) begin
      {timer_cs_req, cs_level_req} <= 10'h1 << i;
      repeat (4) @(posedge pclk);
      {timer_cs_req, cs_level_req} <= 10'h0;
      stat(32'h400, 32'h400);
      cs_cycle_end <= 1'b1;
      repeat (4) @(posedge pclk);
      cs_cycle_end <= 1'b0;
      stat(32'h400, 32'h0);
    end
    {irq_request, irq_enable} <= 2'b11;
    repeat (6) @(posedge pclk);
    chk(int_service_ff, 1'b1);
    irq_request <= 1'b0;
    apb(1'b1, `OFS_SHIFTCNT, 32'h0);
    setc(bit_of(`C_CYC_I2), `STEP_T7);
    chk(int_service_ff, 1'b0);
    $display("test service flags done");
    summarize;
  end

  // Whole run is a few hundred cycles; this only cuts a hang short
  initial begin
    repeat (20000) @(posedge pclk);
    fails++;
    summarize;
  end
endmodule
